// ---- include/psb_pkg.sv ----
// constants and carrier types for the pci side signal block
package psb_pkg;
  localparam logic [7:0] OFF_MISC  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_ISTAT = 8'h08;
  localparam logic [7:0] OFF_IMASK = 8'h0c;
  localparam int B_MCLK = 0;  // master clocking mode
  localparam int B_BRST = 1;  // hold secondary bus in reset
  localparam int B_PARK = 8;
  localparam int B_EXT  = 9;  // external arbiter
  localparam logic [9:0] MISC_RST = 10'h002;
  localparam int S_SPEED = 0;
  localparam int S_GRANT = 1;
  localparam int S_LAST  = 2;  // two bits, last granted master
  localparam int I_PERR = 0;
  localparam int I_SERR = 1;
  localparam int I_PME  = 2;
  localparam logic [2:0] IMASK_RST = 3'h0;

  // asynchronous bus pins as sampled
  typedef struct packed {
    logic        clk;
    logic [31:0] ad;
    logic [3:0]  cbeN;
    logic        par;
    logic        frameN;
    logic        irdyN;
    logic        trdyN;
    logic [3:0]  reqN;
    logic        gnt0N;
    logic        speedSel;
    logic        powerEventN;
  } psb_pins_type;

  // requests from the bridge core, same clock
  typedef struct packed {
    logic adOe;
    logic tgtSel;
    logic tgtReady;
    logic tgtStop;
    logic mstSel;
    logic mstReady;
    logic mstReq;
  } psb_core_type;

  // pin drive values and enables
  typedef struct packed {
    logic       busParity;
    logic       busParityOe;
    logic       dataParityErrorN;
    logic       dataParityErrorOe;
    logic       systemErrorN;
    logic       systemErrorOe;
    logic       targetReadyN;
    logic       targetReadyOe;
    logic       targetStopN;
    logic       targetStopOe;
    logic       initiatorReadyN;
    logic       initiatorReadyOe;
    logic       busRequest0N;
    logic       busRequest0Oe;
    logic [3:0] busGrantN;
    logic [3:0] busGrantOe;
    logic       secondaryBusResetN;
  } psb_drive_type;

  typedef struct packed {
    psb_pins_type  s1;
    psb_pins_type  s2;
    psb_pins_type  pv;
    logic [31:0]   adQ;
    logic [3:0]    cbeQ;
    logic          addrQ;
    logic          dataQ;
    logic          frameQ;  // frame level at the last bus clock edge
    logic          droveQ;
    logic          involvedQ;
    logic [1:0]    lastM;
    logic [9:0]    misc;
    logic [2:0]    istat;
    logic [2:0]    imask;
    logic          speed66;
    logic          ack;
    logic [31:0]   rdat;
    logic          irq;
    psb_drive_type drv;
  } psb_state_type;
endpackage

// ---- src/psb_pci_side.sv ----
// pci side signal logic: parity, errors, arbiter lines, handshakes, registers
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
module psb_pci_side
  import psb_pkg::*;
(
  // system
  input  wire logic          clock,
  input  wire logic          rst,
  // wishbone slave
  input  wire logic          wbCyc,
  input  wire logic          wbStb,
  input  wire logic          wbWe,
  input  wire logic [3:0]    wbSel,
  input  wire logic [7:0]    wbAdr,
  input  wire logic [31:0]   wbDatI,
  output logic [31:0]        wbDatO,
  output logic               wbAck,
  // bus pins and core
  input  wire psb_pins_type  pinsIn,
  input  wire psb_core_type  coreIn,
  output psb_drive_type      pinDrive,
  output logic               irq
);
  psb_state_type st_r;
  psb_state_type st_nxt;
  logic          pe;
  logic          adPhase;
  logic          dataPhase;
  logic          parBad;

  // even parity: the bit that makes the total count of ones even
  function automatic logic evenPar(input logic [31:0] ad, input logic [3:0] cbe);
    evenPar = ^{ad, cbe};
  endfunction

  // bus clock is only sampled, so its rising edge is a one-cycle pulse
  assign pe        = st_r.s2.clk & ~st_r.pv.clk;
  // pv is only one system clock old, so a frame fall is judged against the last bus clock
  assign adPhase   = ~st_r.s2.frameN & st_r.frameQ;
  assign dataPhase = ~st_r.s2.irdyN & ~st_r.s2.trdyN;
  assign parBad    = st_r.s2.par != evenPar(st_r.adQ, st_r.cbeQ);

  // next state
  always_comb begin
    logic        found;
    logic [1:0]  idx;
    logic [1:0]  pick;
    logic [2:0]  ev;
    logic        hit;
    found = 1'b0;
    idx = 2'h0;
    pick = 2'h0;
    ev = 3'h0;
    st_nxt = st_r;
    hit = wbCyc & wbStb & ~st_r.ack;
    // two flops on every pin before use; s1 feeds only s2
    st_nxt.s1 = pinsIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.pv = st_r.s2;
    // speed only counts in master clocking mode
    st_nxt.speed66 = st_r.misc[B_MCLK] & st_r.s2.speedSel;
    st_nxt.drv.secondaryBusResetN = ~st_r.misc[B_BRST];
    // request and grant directions follow the arbiter mode
    if (st_r.misc[B_EXT]) begin
      st_nxt.drv.busRequest0Oe = 1'b1;
      st_nxt.drv.busRequest0N  = ~coreIn.mstReq;
      st_nxt.drv.busGrantOe    = 4'he;
      st_nxt.drv.busGrantN     = 4'hf;
    end else begin
      st_nxt.drv.busRequest0Oe = 1'b0;
      st_nxt.drv.busRequest0N  = 1'b1;
      st_nxt.drv.busGrantOe    = 4'hf;
    end
    if (pe) begin
      // capture this phase for the parity of the next bus clock
      st_nxt.adQ       = st_r.s2.ad;
      st_nxt.cbeQ      = st_r.s2.cbeN;
      st_nxt.addrQ     = adPhase;
      st_nxt.dataQ     = dataPhase;
      st_nxt.frameQ    = st_r.s2.frameN;
      st_nxt.droveQ    = coreIn.adOe;
      st_nxt.involvedQ = coreIn.tgtSel | coreIn.mstSel;
      // whoever drove ad last clock drives parity now
      st_nxt.drv.busParityOe = st_r.droveQ;
      st_nxt.drv.busParity   = evenPar(st_r.adQ, st_r.cbeQ);
      // perr is driven high for one clock after a low, then released
      st_nxt.drv.dataParityErrorN  = 1'b1;
      st_nxt.drv.dataParityErrorOe = ~st_r.drv.dataParityErrorN;
      if (st_r.dataQ && st_r.involvedQ && !st_r.droveQ && parBad) begin
        st_nxt.drv.dataParityErrorN  = 1'b0;
        st_nxt.drv.dataParityErrorOe = 1'b1;
        ev[I_PERR] = 1'b1;
      end
      // system error is open drain: only ever pulled low
      st_nxt.drv.systemErrorN  = 1'b0;
      st_nxt.drv.systemErrorOe = st_r.addrQ && !st_r.droveQ && parBad;
      ev[I_SERR] = st_r.addrQ && !st_r.droveQ && parBad;
      // target and master handshakes from the core
      st_nxt.drv.targetReadyOe    = coreIn.tgtSel;
      st_nxt.drv.targetReadyN     = ~coreIn.tgtReady;
      st_nxt.drv.targetStopOe     = coreIn.tgtSel;
      st_nxt.drv.targetStopN      = ~coreIn.tgtStop;
      st_nxt.drv.initiatorReadyOe = coreIn.mstSel;
      st_nxt.drv.initiatorReadyN  = ~coreIn.mstReady;
      // round robin arbiter, grants move only while the bus is idle
      if (!st_r.misc[B_EXT] && st_r.s2.frameN && st_r.s2.irdyN) begin
        for (int i = 1; i <= 4; i++) begin
          idx = 2'(int'(st_r.lastM) + i);
          if (!found && !st_r.s2.reqN[idx]) begin
            found = 1'b1;
            pick = idx;
          end
        end
        if (found) begin
          st_nxt.drv.busGrantN = ~(4'h1 << pick);
          st_nxt.lastM = pick;
        end else if (!st_r.misc[B_PARK]) begin
          st_nxt.drv.busGrantN = 4'hf;
        end  // parked: grant left on the last master
      end
    end
    // falling power event, sampled on our own clock
    ev[I_PME] = ~st_r.s2.powerEventN & st_r.pv.powerEventN;
    // wishbone: one wait state, ack for one cycle
    st_nxt.ack = hit;
    st_nxt.rdat = 32'h0;
    if (hit && wbWe) begin
      if (wbAdr == OFF_MISC) begin
        if (wbSel[0]) st_nxt.misc[7:0] = wbDatI[7:0];
        if (wbSel[1]) st_nxt.misc[9:8] = wbDatI[9:8];
      end else if (wbAdr == OFF_ISTAT) begin
        if (wbSel[0]) st_nxt.istat = st_r.istat & ~wbDatI[2:0];
      end else if (wbAdr == OFF_IMASK) begin
        if (wbSel[0]) st_nxt.imask = wbDatI[2:0];
      end
    end else if (hit) begin
      if (wbAdr == OFF_MISC) begin
        st_nxt.rdat[9:0] = st_r.misc;
      end else if (wbAdr == OFF_STAT) begin
        st_nxt.rdat[S_SPEED] = st_r.speed66;
        st_nxt.rdat[S_GRANT] = st_r.misc[B_EXT] & ~st_r.s2.gnt0N;
        st_nxt.rdat[S_LAST +: 2] = st_r.lastM;
      end else if (wbAdr == OFF_ISTAT) begin
        st_nxt.rdat[2:0] = st_r.istat;
      end else if (wbAdr == OFF_IMASK) begin
        st_nxt.rdat[2:0] = st_r.imask;
      end
    end
    // a new event wins over a clear in the same cycle
    st_nxt.istat = st_nxt.istat | ev;
    st_nxt.irq = |(st_r.istat & st_r.imask);
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.s1 <= '1;
      st_r.s2 <= '1;
      st_r.pv <= '1;
      st_r.frameQ <= 1'b1;  // idle frame, so the first address phase is seen
      st_r.misc <= MISC_RST;
      st_r.imask <= IMASK_RST;
      st_r.drv.dataParityErrorN <= 1'b1;
      st_r.drv.targetReadyN <= 1'b1;
      st_r.drv.targetStopN <= 1'b1;
      st_r.drv.initiatorReadyN <= 1'b1;
      st_r.drv.busRequest0N <= 1'b1;
      st_r.drv.busGrantN <= 4'hf;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wbDatO   = st_r.rdat;
  assign wbAck    = st_r.ack;
  assign pinDrive = st_r.drv;
  assign irq      = st_r.irq;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_par;
    pe && st_r.droveQ |=> st_r.drv.busParityOe && st_r.drv.busParity == ^{$past(st_r.adQ), $past(st_r.cbeQ)};
  endproperty
  a_par: assert property (p_par) else $error("parity not driven");

  property p_serr;
    pe && st_r.addrQ && !st_r.droveQ && parBad |=> st_r.drv.systemErrorOe && st_r.istat[I_SERR];
  endproperty
  a_serr: assert property (p_serr) else $error("address parity error missed");

  property p_perr;
    pe && st_r.dataQ && st_r.involvedQ && !st_r.droveQ && parBad |=>
      st_r.drv.dataParityErrorOe && !st_r.drv.dataParityErrorN && st_r.istat[I_PERR];
  endproperty
  a_perr: assert property (p_perr) else $error("data parity error missed");

  property p_ext;
    st_r.misc[B_EXT] |=> st_r.drv.busRequest0Oe && st_r.drv.busGrantOe == 4'he;
  endproperty
  a_ext: assert property (p_ext) else $error("external arbiter directions wrong");

  property p_int;
    !rst && !st_r.misc[B_EXT] |=> !st_r.drv.busRequest0Oe && st_r.drv.busGrantOe == 4'hf;
  endproperty
  a_int: assert property (p_int) else $error("internal arbiter directions wrong");

  property p_speed;
    ##1 st_r.speed66 == ($past(st_r.misc[B_MCLK]) && $past(st_r.s2.speedSel));
  endproperty
  a_speed: assert property (p_speed) else $error("speed flag wrong");

  property p_brst;
    st_r.misc[B_BRST] |=> !st_r.drv.secondaryBusResetN;
  endproperty
  a_brst: assert property (p_brst) else $error("bus reset not driven");

  property p_hand;
    pe && coreIn.tgtSel |=> st_r.drv.targetReadyOe && st_r.drv.targetStopOe &&
      st_r.drv.targetReadyN == !$past(coreIn.tgtReady) && st_r.drv.targetStopN == !$past(coreIn.tgtStop);
  endproperty
  a_hand: assert property (p_hand) else $error("target handshake wrong");

  property p_park;
    pe && !st_r.misc[B_EXT] && st_r.misc[B_PARK] && (&st_r.s2.reqN) |=> $stable(st_r.drv.busGrantN);
  endproperty
  a_park: assert property (p_park) else $error("park lost");

  // our own request line follows the core while an external arbiter rules
  property p_req0;
    !rst && st_r.misc[B_EXT] |=> st_r.drv.busRequest0N == !$past(coreIn.mstReq);
  endproperty
  a_req0: assert property (p_req0) else $error("request zero wrong");

  // the internal arbiter never grants two masters at once
  property p_grant_one;
    st_r.drv.busGrantOe == 4'hf |-> $countones(~st_r.drv.busGrantN) <= 1;
  endproperty
  a_grant_one: assert property (p_grant_one) else $error("more than one grant");

  // without parking an idle bus with no requests has every grant high
  property p_unpark;
    pe && !st_r.misc[B_EXT] && !st_r.misc[B_PARK] && (&st_r.s2.reqN) && st_r.s2.frameN && st_r.s2.irdyN
      |=> st_r.drv.busGrantN == 4'hf;
  endproperty
  a_unpark: assert property (p_unpark) else $error("grant left without park");

  // a low error pin is driven high for one bus clock before release
  property p_perr_release;
    pe && st_r.drv.dataParityErrorOe && !st_r.drv.dataParityErrorN && !st_r.dataQ |=>
      st_r.drv.dataParityErrorOe && st_r.drv.dataParityErrorN;
  endproperty
  a_perr_release: assert property (p_perr_release) else $error("parity error pin not restored");

  // master ready follows the core at each bus clock
  property p_irdy;
    pe && coreIn.mstSel |=> st_r.drv.initiatorReadyOe && st_r.drv.initiatorReadyN == !$past(coreIn.mstReady);
  endproperty
  a_irdy: assert property (p_irdy) else $error("initiator ready wrong");

  // a falling power event input always lands in the status register
  property p_pme;
    !st_r.s2.powerEventN && st_r.pv.powerEventN |=> st_r.istat[I_PME];
  endproperty
  a_pme: assert property (p_pme) else $error("power event missed");

  c_serr: cover property (pe && st_r.addrQ && parBad);
  c_park: cover property (pe && st_r.misc[B_PARK] && !(&st_r.drv.busGrantN));
  c_ext:  cover property (st_r.drv.busRequest0Oe && !st_r.drv.busRequest0N);
  c_perr: cover property (st_r.drv.dataParityErrorOe && !st_r.drv.dataParityErrorN);
  c_pme:  cover property (st_r.istat[I_PME] && st_r.irq);
endmodule

// ---- tb/psb_pci_agent.sv ----
// far-side pci agent model: master stimulus, parity source and pme source
`timescale 1ns/10ps
module psb_pci_agent
  import psb_pkg::*;
(
  // wire levels seen by the bridge
  output psb_pins_type pins
);
  logic [35:0] prevBits;
  logic        prevBad;

  // idle bus: pulled-up lines high, link clock parked low between phases
  initial begin
    pins     = '1;
    pins.clk = 1'b0;
    prevBits = '0;
    prevBad  = 1'b0;
  end

  // one pci clock; parity of the previous phase goes out now
  task automatic phase(input logic frameN, input logic irdyN, input logic trdyN,
                       input logic [31:0] ad, input logic [3:0] cbeN, input logic bad);
    pins.par    <= (^prevBits) ^ prevBad;
    pins.frameN <= frameN;
    pins.irdyN  <= irdyN;
    pins.trdyN  <= trdyN;
    pins.ad     <= ad;
    pins.cbeN   <= cbeN;
    prevBits    = {ad, cbeN};
    prevBad     = bad;
    #80 pins.clk <= 1'b1;
    #80 pins.clk <= 1'b0;
  endtask

  // a power event holds the line low for one pci clock
  task automatic pme();
    pins.powerEventN <= 1'b0;
    #160 pins.powerEventN <= 1'b1;
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the pci side signal block
`timescale 1ns/10ps
module testbench;
  import psb_pkg::*;
  logic          clock, rst, wbCyc, wbStb, wbWe, wbAck, irq, clrSeen, expPar;
  logic [3:0]    wbSel;
  logic [7:0]    wbAdr;
  logic [31:0]   wbDatI, wbDatO, rd;
  logic [5:0]    seen;
  psb_pins_type  pinsIn;
  psb_core_type  coreIn;
  psb_drive_type pinDrive;
  int            numErrors, testsRun;

  psb_pci_agent agent (.pins(pinsIn));
  psb_pci_side DUT (.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel),
    .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .pinsIn(pinsIn), .coreIn(coreIn),
    .pinDrive(pinDrive), .irq(irq));

  // 250 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // sticky record of pin events, since they last only one pci clock
  always @(posedge clock) begin
    if (clrSeen) seen <= '0;
    else seen <= seen | {pinDrive.busParityOe && pinDrive.busParity === expPar,
      pinDrive.initiatorReadyOe & ~pinDrive.initiatorReadyN, pinDrive.targetStopOe & ~pinDrive.targetStopN,
      pinDrive.targetReadyOe & ~pinDrive.targetReadyN, pinDrive.dataParityErrorOe & ~pinDrive.dataParityErrorN,
      pinDrive.systemErrorOe & ~pinDrive.systemErrorN};
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // classic single wishbone cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbDatI <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    if (n >= 20) chk("ack", 1'b1, 1'b0);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic idle(input int n);
    repeat (n) agent.phase(1'b1, 1'b1, 1'b1, 32'h0, 4'h0, 1'b0);
  endtask

  task automatic done(input string nm);
    clrSeen <= 1'b1;
    @(posedge clock);
    clrSeen <= 1'b0;
    $display("test %s done", nm);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 100 us
  initial begin
    #100000;
    numErrors++;
    finish_test();
  end

  initial begin
    {rst, clrSeen, numErrors, testsRun} = {2'b11, 64'h0};
    {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatI, expPar} = {3'h0, 4'hf, 41'h0};
    coreIn = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("bus reset", 1'b0, pinDrive.secondaryBusResetN);
    wb(OFF_MISC, 1'b0, 32'h0);
    chk("misc", 32'h002, rd);
    wb(OFF_IMASK, 1'b0, 32'h0);
    chk("imask", 32'h0, rd);
    wb(8'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(OFF_MISC, 1'b1, 32'h001);
    chk("bus reset", 1'b1, pinDrive.secondaryBusResetN);
    done("reset");
    // speed select counts only in master clocking mode
    agent.pins.speedSel <= 1'b1;
    repeat (4) @(posedge clock);  // let the pin pass its two sync flops
    wb(OFF_STAT, 1'b0, 32'h0);
    chk("speed66", 1'b1, rd[S_SPEED]);
    wb(OFF_MISC, 1'b1, 32'h000);
    wb(OFF_STAT, 1'b0, 32'h0);
    chk("speed slave", 1'b0, rd[S_SPEED]);
    wb(OFF_MISC, 1'b1, 32'h001);
    agent.pins.speedSel <= 1'b0;
    repeat (4) @(posedge clock);  // speed flag lags the pin by the sync flops
    wb(OFF_STAT, 1'b0, 32'h0);
    chk("speed33", 1'b0, rd[S_SPEED]);
    done("speed");
    // bad address parity raises system error and the interrupt
    wb(OFF_IMASK, 1'b1, 32'h7);
    agent.phase(1'b0, 1'b1, 1'b1, 32'h1234_5678, 4'h6, 1'b1);
    agent.phase(1'b0, 1'b0, 1'b1, 32'h0, 4'h0, 1'b0);
    idle(1);
    chk("serr", 1'b1, seen[0]);
    chk("irq", 1'b1, irq);
    wb(OFF_ISTAT, 1'b1, 32'h7);
    chk("irq clear", 1'b0, irq);
    done("address parity");
    // bad write data while we are target
    coreIn.tgtSel <= 1'b1;
    agent.phase(1'b0, 1'b1, 1'b1, 32'h0000_0100, 4'h7, 1'b0);
    agent.phase(1'b1, 1'b0, 1'b0, 32'h5a5a_0f0f, 4'h0, 1'b1);
    idle(2);
    chk("perr", 1'b1, seen[1]);
    wb(OFF_ISTAT, 1'b0, 32'h0);
    chk("istat perr", 1'b1, rd[I_PERR]);
    done("data parity");
    // handshakes and parity that we drive, odd one counts so parity is one
    coreIn <= 7'h7e;
    expPar <= 1'b1;
    agent.phase(1'b0, 1'b0, 1'b0, 32'hcafe_0003, 4'h3, 1'b0);
    repeat (2) agent.phase(1'b1, 1'b1, 1'b1, 32'h1, 4'h0, 1'b0);
    chk("trdy", 1'b1, seen[2]);
    chk("stop", 1'b1, seen[3]);
    chk("irdy", 1'b1, seen[4]);
    chk("parity out", 1'b1, seen[5]);
    coreIn <= 7'h01;
    done("handshake");
    // request and grant directions follow the arbiter mode bit
    wb(OFF_MISC, 1'b1, 32'h200);
    chk("req0 oe", 1'b1, pinDrive.busRequest0Oe);
    chk("req0", 1'b0, pinDrive.busRequest0N);
    chk("gnt oe ext", 4'he, pinDrive.busGrantOe);
    agent.pins.gnt0N <= 1'b0;
    repeat (4) @(posedge clock);
    wb(OFF_STAT, 1'b0, 32'h0);
    chk("grant0 seen", 1'b1, rd[S_GRANT]);
    agent.pins.gnt0N <= 1'b1;
    wb(OFF_MISC, 1'b1, 32'h000);
    chk("req0 in", 1'b0, pinDrive.busRequest0Oe);
    chk("gnt oe int", 4'hf, pinDrive.busGrantOe);
    coreIn <= 7'h00;
    // parking keeps the last grant after requests go away
    wb(OFF_MISC, 1'b1, 32'h100);
    agent.pins.reqN <= 4'hb;
    idle(2);
    agent.pins.reqN <= 4'hf;
    idle(2);
    chk("parked", 4'hb, pinDrive.busGrantN);
    wb(OFF_STAT, 1'b0, 32'h0);
    chk("last master", 2'h2, rd[S_LAST +: 2]);
    wb(OFF_MISC, 1'b1, 32'h000);
    idle(2);
    chk("unparked", 4'hf, pinDrive.busGrantN);
    done("arbiter");
    // power event latched while masked, interrupt follows the mask
    wb(OFF_IMASK, 1'b1, 32'h0);
    wb(OFF_ISTAT, 1'b1, 32'h7);
    agent.pme();
    wb(OFF_ISTAT, 1'b0, 32'h0);
    chk("istat pme", 3'h4, rd[2:0]);
    chk("irq masked", 1'b0, irq);
    wb(OFF_IMASK, 1'b1, 32'h4);
    chk("irq unmasked", 1'b1, irq);
    done("power event");
    finish_test();
  end
endmodule
